/* rtl/spc_pkg.sv */
// Package for the supply monitor and stop-mode power control block.
// Assumes a single 40 MHz system clock and a plain register port.
package spc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [4:0] ADDR_POWER_STOP_CONTROL = 5'h0c;
  localparam logic [4:0] ADDR_SUPPLY_MONITOR_CONTROL = 5'h0d;
  // Power control fields
  localparam int PWR_BROWNOUT_KEEP_BIT = 7;
  localparam int PWR_REGULATOR_KEEP_BIT = 6;
  localparam int PWR_XTAL_DISABLE_BIT = 0;
  localparam logic [7:0] PWR_POR_VALUE = 8'h00;
  // Monitor fields
  localparam int MON_THRESH_LSB = 8;
  localparam int MON_THRESH_MSB = 11;
  localparam int MON_STOP_KEEP_BIT = 4;
  localparam int MON_FLAG_BIT = 3;
  localparam int MON_IRQ_EN_BIT = 2;
  localparam int MON_READY_BIT = 1;
  localparam int MON_ENABLE_BIT = 0;
  localparam logic [3:0] MON_THRESH_RESET = 4'h7;
  // Warm-up time in microseconds, converted to cycles
  localparam int unsigned WARMUP_US = 10;
  localparam int unsigned WARMUP_CYCLES = (WARMUP_US * (CLK_HZ / 1000000));
  localparam int WARM_W = 16;

  typedef enum logic [1:0] {
    SPC_MON_OFF = 2'b00,
    SPC_MON_WARM = 2'b01,
    SPC_MON_READY = 2'b10
  } spc_mon_state_t;

  typedef struct packed {
    logic brownout_stop_keep;
    logic regulator_stop_keep;
    logic crystal_osc_disable;
  } spc_pwr_t;

  typedef struct packed {
    logic [3:0] supply_threshold_code;
    logic monitor_stop_keep;
    logic supply_low_flag;
    logic supply_low_irq_enable;
    logic monitor_enable;
  } spc_mon_t;

  typedef struct packed {
    spc_mon_t mon;
    spc_mon_state_t st;
    logic [WARM_W-1:0] warm_cnt;
    logic [15:0] rdata;
    logic cmp_meta;
    logic cmp_sync;
    logic stop_meta;
    logic stop_sync;
    logic rosc_sel_meta;
    logic rosc_sel_sync;
    logic rosc_act_meta;
    logic rosc_act_sync;
    logic regulator_on;
    logic brownout_on;
    logic comparator_on;
    logic [3:0] comparator_code;
    logic irq;
    logic wake;
    logic switchback;
  } spc_state_t;
endpackage

/* rtl/spc_supply_power.sv */
// Supply monitor and stop-mode power control registers and sequencing.
// Assumes synchronous register port; analog, stop and oscillator levels are asynchronous pins.
`timescale 1ns/1ps
// What this block does
// - Brownout detection off in stop unless brownout keep or regulator keep set
// - Regulator always on outside stop; in stop follows regulator keep bit
// - Power register bits 5:1 read as zero
// - Crystal disable write of 1 accepted only when ring select and active
// - Crystal disable bit drives oscillator disable output
// - Threshold code writable only while monitor disabled
// - Threshold code passed to comparator; trip is 2.0V plus code times 0.1V
// - Reset loads threshold 0111 and clears other monitor bits
// - Monitor runs in stop only when stop keep and enable both set
// - Low-supply flag set while monitor ready and comparator reports supply below threshold
// - Flag writable by software; any rise raises interrupt when enabled
// - Only software clears flag; hardware sets it again if still low
// - Interrupt request is flag gated by its enable
// - Ready is 0 when disabled, warming up, or stopped without stop keep
// - Ready is 1 only after enable and warm-up; read-only
// - Enable starts comparison; clearing enable stops monitor
// - Power register cleared only by power-on reset, kept on standard reset
// - Monitor interrupt serves as stop wake-up and switchback trigger
module spc_supply_power #(
  parameter int unsigned WARMUP_COUNT = spc_pkg::WARMUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_resetn,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic supply_below_threshold,
  input wire logic stop_mode,
  input wire logic ring_osc_select,
  input wire logic ring_osc_active,
  output logic regulator_on,
  output logic brownout_on,
  output logic crystal_osc_disable,
  output logic comparator_on,
  output logic [3:0] comparator_code,
  output logic irq,
  output logic wake_request,
  output logic switchback_request
);
  spc_pkg::spc_state_t s_r;
  spc_pkg::spc_state_t s_nxt;
  spc_pkg::spc_pwr_t pwr_r;
  spc_pkg::spc_pwr_t pwr_nxt;

  localparam int unsigned WARM_LAST_N = (WARMUP_COUNT > 1) ? WARMUP_COUNT - 1 : 0;
  localparam logic [spc_pkg::WARM_W-1:0] WARM_LAST = WARM_LAST_N[spc_pkg::WARM_W-1:0];

  logic wr_pwr;
  logic wr_mon;
  logic mon_active;
  logic flag_next;

  assign wr_pwr = wr && (addr == spc_pkg::ADDR_POWER_STOP_CONTROL);
  assign wr_mon = wr && (addr == spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL);

  // Power control bits live apart since only power-on reset clears them
  always_comb begin
    pwr_nxt = pwr_r;
    if (wr_pwr) begin
      pwr_nxt.brownout_stop_keep = wdata[spc_pkg::PWR_BROWNOUT_KEEP_BIT];
      pwr_nxt.regulator_stop_keep = wdata[spc_pkg::PWR_REGULATOR_KEEP_BIT];
      if (!wdata[spc_pkg::PWR_XTAL_DISABLE_BIT]) begin
        pwr_nxt.crystal_osc_disable = 1'b0;
      end else if (s_r.rosc_sel_sync && s_r.rosc_act_sync) begin
        pwr_nxt.crystal_osc_disable = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge por_resetn) begin
    if (!por_resetn) begin
      pwr_r.brownout_stop_keep <= spc_pkg::PWR_POR_VALUE[spc_pkg::PWR_BROWNOUT_KEEP_BIT];
      pwr_r.regulator_stop_keep <= spc_pkg::PWR_POR_VALUE[spc_pkg::PWR_REGULATOR_KEEP_BIT];
      pwr_r.crystal_osc_disable <= spc_pkg::PWR_POR_VALUE[spc_pkg::PWR_XTAL_DISABLE_BIT];
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  always_comb begin
    s_nxt = s_r;
    mon_active = 1'b0;
    flag_next = s_r.mon.supply_low_flag;
    // Two-flop synchronisers for every asynchronous level
    s_nxt.cmp_meta = supply_below_threshold;
    s_nxt.cmp_sync = s_r.cmp_meta;
    s_nxt.stop_meta = stop_mode;
    s_nxt.stop_sync = s_r.stop_meta;
    s_nxt.rosc_sel_meta = ring_osc_select;
    s_nxt.rosc_sel_sync = s_r.rosc_sel_meta;
    s_nxt.rosc_act_meta = ring_osc_active;
    s_nxt.rosc_act_sync = s_r.rosc_act_meta;

    if (wr_mon) begin
      s_nxt.mon.monitor_enable = wdata[spc_pkg::MON_ENABLE_BIT];
      s_nxt.mon.supply_low_irq_enable = wdata[spc_pkg::MON_IRQ_EN_BIT];
      s_nxt.mon.monitor_stop_keep = wdata[spc_pkg::MON_STOP_KEEP_BIT];
      flag_next = wdata[spc_pkg::MON_FLAG_BIT];
      if (!s_r.mon.monitor_enable) begin
        s_nxt.mon.supply_threshold_code = wdata[spc_pkg::MON_THRESH_MSB:spc_pkg::MON_THRESH_LSB];
      end
    end

    // Monitor is powered when enabled, and in stop only with stop keep
    mon_active = s_r.mon.monitor_enable && (!s_r.stop_sync || s_r.mon.monitor_stop_keep);

    case (s_r.st)
      spc_pkg::SPC_MON_OFF: begin
        s_nxt.warm_cnt = '0;
        if (mon_active) begin
          s_nxt.st = spc_pkg::SPC_MON_WARM;
        end
      end
      spc_pkg::SPC_MON_WARM: begin
        if (!mon_active) begin
          s_nxt.st = spc_pkg::SPC_MON_OFF;
        end else if (s_r.warm_cnt >= WARM_LAST) begin
          s_nxt.st = spc_pkg::SPC_MON_READY;
        end else begin
          s_nxt.warm_cnt = s_r.warm_cnt + 1'b1;
        end
      end
      spc_pkg::SPC_MON_READY: begin
        if (!mon_active) begin
          s_nxt.st = spc_pkg::SPC_MON_OFF;
        end
      end
      default: begin
        s_nxt.st = spc_pkg::SPC_MON_OFF;
      end
    endcase

    // Hardware set wins over a software clear in the same cycle
    if (s_r.st == spc_pkg::SPC_MON_READY && mon_active && s_r.cmp_sync) begin
      flag_next = 1'b1;
    end
    s_nxt.mon.supply_low_flag = flag_next;

    s_nxt.regulator_on = !s_r.stop_sync || pwr_r.regulator_stop_keep;
    s_nxt.brownout_on = !s_r.stop_sync || pwr_r.brownout_stop_keep || pwr_r.regulator_stop_keep;
    s_nxt.comparator_on = mon_active;
    s_nxt.comparator_code = s_r.mon.supply_threshold_code;
    s_nxt.irq = flag_next && s_nxt.mon.supply_low_irq_enable;
    s_nxt.wake = s_nxt.irq && s_r.stop_sync;
    s_nxt.switchback = s_nxt.irq && !s_r.stop_sync;

    s_nxt.rdata = '0;
    if (rd) begin
      case (addr)
        spc_pkg::ADDR_POWER_STOP_CONTROL: begin
          s_nxt.rdata[spc_pkg::PWR_BROWNOUT_KEEP_BIT] = pwr_r.brownout_stop_keep;
          s_nxt.rdata[spc_pkg::PWR_REGULATOR_KEEP_BIT] = pwr_r.regulator_stop_keep;
          s_nxt.rdata[spc_pkg::PWR_XTAL_DISABLE_BIT] = pwr_r.crystal_osc_disable;
        end
        spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL: begin
          s_nxt.rdata[spc_pkg::MON_THRESH_MSB:spc_pkg::MON_THRESH_LSB] = s_r.mon.supply_threshold_code;
          s_nxt.rdata[spc_pkg::MON_STOP_KEEP_BIT] = s_r.mon.monitor_stop_keep;
          s_nxt.rdata[spc_pkg::MON_FLAG_BIT] = s_r.mon.supply_low_flag;
          s_nxt.rdata[spc_pkg::MON_IRQ_EN_BIT] = s_r.mon.supply_low_irq_enable;
          s_nxt.rdata[spc_pkg::MON_READY_BIT] = (s_r.st == spc_pkg::SPC_MON_READY);
          s_nxt.rdata[spc_pkg::MON_ENABLE_BIT] = s_r.mon.monitor_enable;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.mon.supply_threshold_code <= spc_pkg::MON_THRESH_RESET;
      s_r.regulator_on <= 1'b1;
      s_r.brownout_on <= 1'b1;
      s_r.st <= spc_pkg::SPC_MON_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign regulator_on = s_r.regulator_on;
  assign brownout_on = s_r.brownout_on;
  // Taken from the power-on register so a standard reset cannot restart the oscillator
  assign crystal_osc_disable = pwr_r.crystal_osc_disable;
  assign comparator_on = s_r.comparator_on;
  assign comparator_code = s_r.comparator_code;
  assign irq = s_r.irq;
  assign wake_request = s_r.wake;
  assign switchback_request = s_r.switchback;
endmodule

/* bench/spc_supply_power_props.sv */
// Assertion checker for the supply monitor and power control block.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ps
module spc_supply_power_props #(
  parameter int unsigned WARMUP_COUNT = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_resetn,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic supply_below_threshold,
  input wire logic stop_mode,
  input wire logic ring_osc_select,
  input wire logic ring_osc_active,
  input wire logic regulator_on,
  input wire logic brownout_on,
  input wire logic crystal_osc_disable,
  input wire logic comparator_on,
  input wire logic [3:0] comparator_code,
  input wire logic irq,
  input wire logic wake_request,
  input wire logic switchback_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence pwr_read_s; rd && addr == spc_pkg::ADDR_POWER_STOP_CONTROL; endsequence
  sequence mon_read_s; rd && addr == spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL; endsequence
  sequence irq_arm_s; wr && addr == spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL && wdata[3:2] == 2'b11; endsequence
  sequence irq_block_s; wr && addr == spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL && !wdata[2]; endsequence
  pwr_reserved_a: assert property (pwr_read_s |=> rdata[15:8] == 8'h00 && rdata[5:1] == 5'h00)
    else $error("power register reserved bits read nonzero");
  mon_reserved_a: assert property (mon_read_s |=> rdata[15:12] == 4'h0 && rdata[7:5] == 3'h0)
    else $error("monitor register reserved bits read nonzero");
  ready_needs_en_a: assert property (mon_read_s |=> !rdata[1] || rdata[0])
    else $error("ready read high with monitor disabled");
  regulator_run_a: assert property (!stop_mode [*4] |-> regulator_on)
    else $error("regulator off outside stop mode");
  brownout_run_a: assert property (!stop_mode [*4] |-> brownout_on)
    else $error("brownout detection off outside stop mode");
  xtal_gate_a: assert property ($rose(crystal_osc_disable) |-> $past(ring_osc_select) && $past(ring_osc_active))
    else $error("crystal disabled without ring oscillator running");
  code_hold_a: assert property (comparator_on && $past(comparator_on) |-> $stable(comparator_code))
    else $error("threshold changed while monitor running");
  irq_arm_a: assert property (irq_arm_s |-> ##[1:3] irq)
    else $error("software flag set raised no interrupt");
  irq_block_a: assert property (irq_block_s |=> !irq)
    else $error("interrupt stayed with enable cleared");
  wake_excl_a: assert property (!(wake_request && switchback_request))
    else $error("wake and switchback requested together");
  wake_source_a: assert property ((wake_request || switchback_request) == irq)
    else $error("wake or switchback request out of step with interrupt");
endmodule

bind spc_supply_power spc_supply_power_props #(.WARMUP_COUNT(WARMUP_COUNT)) chk (.clk, .resetn, .por_resetn,
  .addr, .wdata, .wr, .rd, .rdata, .supply_below_threshold, .stop_mode, .ring_osc_select, .ring_osc_active,
  .regulator_on, .brownout_on, .crystal_osc_disable, .comparator_on, .comparator_code, .irq, .wake_request,
  .switchback_request);

/* bench/spc_supply_power_tb_top.sv */
// Self-checking bench for the supply monitor and power control block.
// Drives the register port and level inputs directly; short warm-up count.
`timescale 1ns/1ps
module spc_supply_power_tb_top;
  localparam logic [4:0] PWR = spc_pkg::ADDR_POWER_STOP_CONTROL;
  localparam logic [4:0] MON = spc_pkg::ADDR_SUPPLY_MONITOR_CONTROL;
  logic clk = 1'b0, resetn = 1'b0, por_resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic low = 1'b0, stop = 1'b0, rsel = 1'b0, ract = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [3:0] code;
  logic reg_on, brn_on, xd, cmp_on, irq, wake, swb;
  int bad_count = 0, total_checks = 0, cyc = 0;
  spc_supply_power #(.WARMUP_COUNT(4)) uut (.clk(clk), .resetn(resetn), .por_resetn(por_resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .supply_below_threshold(low), .stop_mode(stop),
    .ring_osc_select(rsel), .ring_osc_active(ract), .regulator_on(reg_on), .brownout_on(brn_on),
    .crystal_osc_disable(xd), .comparator_on(cmp_on), .comparator_code(code), .irq(irq),
    .wake_request(wake), .switchback_request(swb));
  always #12.5 clk = ~clk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stands only until the next edge
    #1;
    chk_w(rdata, e);
  endtask
  // Standard reset for one edge, optionally with power-on reset beside it
  task automatic pulse_reset(input logic por);
    @(posedge clk);
    resetn <= 1'b0;
    if (por) begin
      por_resetn <= 1'b0;
    end
    @(posedge clk);
    resetn <= 1'b1;
    por_resetn <= 1'b1;
    wt(3);
  endtask
  task automatic t_power;
    wr_reg(PWR, 16'hffff);
    rd_chk(PWR, 16'h00c0);
    @(posedge clk) {rsel, ract} <= 2'b11;
    wt(3);
    wr_reg(PWR, 16'h00c1);
    rd_chk(PWR, 16'h00c1);
    chk_b(xd, 1'b1);
    @(posedge clk) stop <= 1'b1;
    wt(5);
    chk_b(reg_on, 1'b1);
    chk_b(brn_on, 1'b1);
    wr_reg(PWR, 16'h0080);
    wt(3);
    chk_b(reg_on, 1'b0);
    chk_b(brn_on, 1'b1);
    chk_b(xd, 1'b0);
    wr_reg(PWR, 16'h0040);
    wt(3);
    chk_b(reg_on, 1'b1);
    chk_b(brn_on, 1'b1);
    wr_reg(PWR, 16'h0000);
    wt(3);
    chk_b(reg_on, 1'b0);
    chk_b(brn_on, 1'b0);
    @(posedge clk) stop <= 1'b0;
    wt(5);
    chk_b(reg_on, 1'b1);
    chk_b(brn_on, 1'b1);
    wr_reg(PWR, 16'h00c1);
    pulse_reset(1'b0);
    rd_chk(PWR, 16'h00c1);
    chk_b(xd, 1'b1);
    rd_chk(MON, 16'h0700);
    pulse_reset(1'b1);
    rd_chk(PWR, 16'h0000);
    chk_b(xd, 1'b0);
    @(posedge clk) ract <= 1'b0;
    wt(3);
    wr_reg(PWR, 16'h0001);
    rd_chk(PWR, 16'h0000);
    $display("test power done");
  endtask
  task automatic t_monitor;
    wr_reg(5'h1f, 16'hffff);
    rd_chk(5'h1f, 16'h0000);
    rd_chk(PWR, 16'h0000);
    wr_reg(MON, 16'hf7e2);
    rd_chk(MON, 16'h0700);
    wr_reg(MON, 16'h0a01);
    rd_chk(MON, 16'h0a01);
    wt(8);
    rd_chk(MON, 16'h0a03);
    chk_w({12'h000, code}, 16'h000a);
    chk_b(cmp_on, 1'b1);
    wr_reg(MON, 16'h0c03);
    rd_chk(MON, 16'h0a03);
    @(posedge clk) low <= 1'b1;
    wt(6);
    rd_chk(MON, 16'h0a0b);
    chk_b(irq, 1'b0);
    wr_reg(MON, 16'h0a05);
    wt(5);
    rd_chk(MON, 16'h0a0f);
    chk_b(irq, 1'b1);
    @(posedge clk) low <= 1'b0;
    wr_reg(MON, 16'h0a09);
    wt(3);
    chk_b(irq, 1'b0);
    wr_reg(MON, 16'h0a0d);
    @(posedge clk) stop <= 1'b1;
    wt(6);
    chk_b(wake, 1'b1);
    chk_b(cmp_on, 1'b0);
    rd_chk(MON, 16'h0a0d);
    @(posedge clk) stop <= 1'b0;
    wt(6);
    chk_b(swb, 1'b1);
    wr_reg(MON, 16'h0a05);
    rd_chk(MON, 16'h0a07);
    chk_b(irq, 1'b0);
    wr_reg(MON, 16'h0a0d);
    wt(1);
    chk_b(irq, 1'b1);
    wt(3);
    rd_chk(MON, 16'h0a0f);
    wr_reg(MON, 16'h0a11);
    @(posedge clk) stop <= 1'b1;
    wt(12);
    chk_b(cmp_on, 1'b1);
    rd_chk(MON, 16'h0a13);
    chk_b(wake, 1'b0);
    wr_reg(MON, 16'h0a15);
    @(posedge clk) low <= 1'b1;
    wt(6);
    chk_b(wake, 1'b1);
    @(posedge clk) low <= 1'b0;
    @(posedge clk) stop <= 1'b0;
    wt(2);
    wr_reg(MON, 16'h0a00);
    wt(3);
    rd_chk(MON, 16'h0a00);
    chk_b(cmp_on, 1'b0);
    wr_reg(MON, 16'h0800);
    rd_chk(MON, 16'h0800);
    chk_w({12'h000, code}, 16'h0008);
    $display("test monitor done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    por_resetn <= 1'b1;
    rd_chk(PWR, 16'h0000);
    rd_chk(MON, 16'h0700);
    chk_b(reg_on, 1'b1);
    chk_b(brn_on, 1'b1);
    chk_w({12'h000, code}, 16'h0007);
    chk_b(irq, 1'b0);
    $display("test reset done");
    t_power();
    t_monitor();
    give_verdict();
  end
endmodule
